/* File: spc_pkg.sv */
package spc_pkg;

  // Decoded command opcodes from the text parser
  typedef enum logic [2:0] {
    SPC_OP_PRESET    = 3'h0,
    SPC_OP_VERSION_Q = 3'h1,
    SPC_OP_ERROR_Q   = 3'h2,
    SPC_OP_SET_COUNT = 3'h3,
    SPC_OP_INITIATE  = 3'h4,
    SPC_OP_ABORT     = 3'h5,
    SPC_OP_RESET     = 3'h6,
    SPC_OP_ESR_CLEAR = 3'h7
  } spc_op_e;

  // Entries held in the error and event queue
  typedef enum logic [1:0] {
    SPC_ERR_NONE      = 2'h0,
    SPC_ERR_SEQ_COUNT = 2'h1
  } spc_err_e;

  // Response text selectors
  typedef enum logic [1:0] {
    SPC_MSG_VERSION   = 2'h0,
    SPC_MSG_NO_ERROR  = 2'h1,
    SPC_MSG_SEQ_COUNT = 2'h2
  } spc_msg_e;

  localparam int          SPC_CNT_W       = 16;
  localparam logic [31:0] SPC_CNT_MIN     = 32'h0000_0001;
  localparam logic [31:0] SPC_CNT_MAX     = 32'h0000_FFFF;
  localparam logic [15:0] SPC_CNT_RST     = 16'h0001;
  localparam int          SPC_IDX_W       = 6;

  localparam int          SPC_VER_LEN     = 7;
  localparam int          SPC_NOERR_LEN   = 13;
  localparam int          SPC_SEQ_LEN     = 49;
  localparam logic [8*SPC_NOERR_LEN-1:0] SPC_NOERR_TXT = "0, \"No error\"";
  localparam logic [8*SPC_SEQ_LEN-1:0]   SPC_SEQ_TXT   =
    "-222, \"Data out of range; Invalid sequence count\"";

endpackage

/* File: spc_errq_if.sv */
`timescale 1ns/1ps
interface spc_errq_if;
  import spc_pkg::*;
  logic     ce;
  logic     push;
  spc_err_e push_code;
  logic     pop;
  logic     empty;
  logic     full;
  spc_err_e head;

  modport ctrl  (output ce, push, push_code, pop, input empty, full, head);
  modport queue (input ce, push, push_code, pop, output empty, full, head);
endinterface

/* File: spc_errq.sv */
`timescale 1ns/1ps
module spc_errq
  import spc_pkg::*;
#(
  parameter int DEPTH = 8
)(
  input  wire logic   clk,
  input  wire logic   reset_n,
  spc_errq_if.queue   q
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_chk
    $error("spc_errq: DEPTH must be a power of two, at least 2");
  end

  spc_err_e         mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    rd_ff;
  logic [PW:0]      cnt_ff;
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    nxt_rd;
  logic [PW:0]      nxt_cnt;
  logic             do_push;
  logic             do_pop;

  assign q.empty = (cnt_ff == '0);
  assign q.full  = (cnt_ff == (PW+1)'(DEPTH));
  assign q.head  = mem_ff[rd_ff];

  always_comb
  begin
    // Overflowing entries are dropped; the oldest ones are kept
    do_push = q.ce && q.push && !q.full;
    do_pop  = q.ce && q.pop && !q.empty;
    nxt_wr  = do_push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = do_pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_ff[wr_ff] <= q.push_code;
  end
endmodule

/* File: spc_ctrl.sv */
`timescale 1ns/1ps
// Operation
// RL1 - System preset command opens every relay and returns no response.
// RL2 - System preset leaves the power-on flag exactly as it was.
// RL3 - Version query places the same fixed text in the output queue.
// RL4 - Pass count accepts 1 through 65535; reset restores 1; no query form.
// RL5 - After initiate, step the whole scan list count complete times.
// RL6 - After the last requested pass, trigger subsystem returns to idle.
// RL7 - Immediate trigger source advances without waiting for trigger events.
// RL8 - Error query pops oldest entry, or returns 0 no-error when empty.
// RL9 - Out-of-range pass count logs -222 invalid sequence count.
// RL10 - Rejected pass count keeps the previously stored count.
module spc_ctrl
  import spc_pkg::*;
#(
  parameter int                         ERRQ_DEPTH   = 8,
  parameter int                         LIST_W       = 12,
  // Version text; value arbitrary
  parameter logic [8*SPC_VER_LEN-1:0]   VERSION_TEXT = "\"0.0.1\""
)(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              cmd_valid,
  input  wire spc_op_e           cmd_op,
  input  wire logic [31:0]       cmd_value,
  output      logic              cmd_ready_ff,
  input  wire logic [LIST_W-1:0] scan_len,
  input  wire logic              trig_src_imm,
  input  wire logic              trig_event,
  output      logic              relays_open_ff,
  output      logic              scan_step_ff,
  output      logic [LIST_W-1:0] scan_chan_ff,
  output      logic              trig_busy_ff,
  output      logic              power_on_flag_ff,
  output      logic              out_valid_ff,
  output      logic [7:0]        out_byte_ff,
  input  wire logic              out_ready
);
  if (LIST_W < 1 || LIST_W > 16)
  begin : g_chk
    $error("spc_ctrl: LIST_W must lie in 1..16");
  end

  typedef enum logic [1:0] { SQ_IDLE = 2'b01, SQ_ARMED = 2'b10 } spc_sq_e;
  typedef enum logic [1:0] { RS_IDLE = 2'b01, RS_SEND  = 2'b10 } spc_rs_e;

  function automatic logic [SPC_IDX_W-1:0] msg_len(input spc_msg_e sel);
    unique case (sel)
      SPC_MSG_VERSION:   msg_len = SPC_IDX_W'(SPC_VER_LEN);
      SPC_MSG_NO_ERROR:  msg_len = SPC_IDX_W'(SPC_NOERR_LEN);
      default:           msg_len = SPC_IDX_W'(SPC_SEQ_LEN);
    endcase
  endfunction

  function automatic logic [7:0] msg_char(input spc_msg_e sel,
                                          input logic [SPC_IDX_W-1:0] idx);
    unique case (sel)
      SPC_MSG_VERSION:   msg_char = VERSION_TEXT[8*(SPC_VER_LEN-1-int'(idx)) +: 8];
      SPC_MSG_NO_ERROR:  msg_char = SPC_NOERR_TXT[8*(SPC_NOERR_LEN-1-int'(idx)) +: 8];
      default:           msg_char = SPC_SEQ_TXT[8*(SPC_SEQ_LEN-1-int'(idx)) +: 8];
    endcase
  endfunction

  spc_errq_if eq ();
  spc_errq #(.DEPTH(ERRQ_DEPTH)) u_errq (.clk(clk), .reset_n(reset_n), .q(eq.queue));

  logic                 take;
  logic                 cnt_ok;
  logic                 step;
  logic                 last_chan;
  logic                 stop;
  logic [SPC_CNT_W-1:0] count_ff,    nxt_count;
  logic [SPC_CNT_W-1:0] passes_ff,   nxt_passes;
  logic [LIST_W-1:0]    nxt_chan;
  spc_sq_e              sq_ff,       nxt_sq;
  spc_rs_e              rs_ff,       nxt_rs;
  spc_msg_e             msg_ff,      nxt_msg;
  logic [SPC_IDX_W-1:0] idx_ff,      nxt_idx;
  logic                 nxt_relays_open;
  logic                 nxt_step;
  logic                 nxt_power_on;
  logic                 nxt_out_valid;
  logic [7:0]           nxt_out_byte;
  logic                 nxt_ready;

  // Command decode and pass-count storage
  always_comb
  begin
    take            = ce && cmd_valid && cmd_ready_ff;
    cnt_ok          = (cmd_value >= SPC_CNT_MIN) && (cmd_value <= SPC_CNT_MAX);
    nxt_count       = count_ff;
    nxt_relays_open = 1'b0;
    nxt_power_on    = power_on_flag_ff;
    eq.ce           = ce;
    eq.push         = 1'b0;
    eq.push_code    = SPC_ERR_SEQ_COUNT;
    eq.pop          = 1'b0;
    if (take)
    begin
      unique case (cmd_op)
        SPC_OP_PRESET:    nxt_relays_open = 1'b1;                   // [RL1] [RL2]
        SPC_OP_SET_COUNT:
          if (cnt_ok)
            nxt_count = cmd_value[SPC_CNT_W-1:0];                   // [RL4]
          else
            eq.push = 1'b1;                                         // [RL9] [RL10]
        SPC_OP_RESET:     nxt_count = SPC_CNT_RST;                  // [RL4]
        SPC_OP_ERROR_Q:   eq.pop = 1'b1;                            // [RL8]
        SPC_OP_ESR_CLEAR: nxt_power_on = 1'b0;
        default:          nxt_count = count_ff;
      endcase
    end
  end

  // Scan sequencer
  always_comb
  begin
    nxt_sq     = sq_ff;
    nxt_passes = passes_ff;
    nxt_chan   = scan_chan_ff;
    // Immediate source steps every cycle, no trigger wait
    step       = (sq_ff == SQ_ARMED) && (trig_src_imm || trig_event);   // [RL7]
    last_chan  = (scan_chan_ff == scan_len - 1'b1);
    nxt_step   = step;
    stop       = take && (cmd_op == SPC_OP_ABORT || cmd_op == SPC_OP_RESET);
    unique case (sq_ff)
      SQ_IDLE:
        // Empty list would never finish a pass, so initiate is ignored
        if (take && cmd_op == SPC_OP_INITIATE && scan_len != '0)
        begin
          nxt_sq     = SQ_ARMED;
          nxt_passes = count_ff;
          nxt_chan   = '0;
        end
      SQ_ARMED:
        if (stop)
        begin
          nxt_sq   = SQ_IDLE;
          nxt_step = 1'b0;
        end
        else if (step)
        begin
          nxt_chan = last_chan ? '0 : scan_chan_ff + 1'b1;          // [RL5]
          if (last_chan)
          begin
            nxt_passes = passes_ff - 1'b1;
            if (passes_ff == SPC_CNT_RST)
              nxt_sq = SQ_IDLE;                                     // [RL6]
          end
        end
    endcase
  end

  // Response streamer into the output queue
  always_comb
  begin
    nxt_rs        = rs_ff;
    nxt_msg       = msg_ff;
    nxt_idx       = idx_ff;
    nxt_out_valid = out_valid_ff;
    nxt_out_byte  = out_byte_ff;
    unique case (rs_ff)
      RS_IDLE:
        if (take && (cmd_op == SPC_OP_VERSION_Q || cmd_op == SPC_OP_ERROR_Q))
        begin
          if (cmd_op == SPC_OP_VERSION_Q)
            nxt_msg = SPC_MSG_VERSION;                              // [RL3]
          else if (eq.empty || eq.head == SPC_ERR_NONE)
            nxt_msg = SPC_MSG_NO_ERROR;                             // [RL8]
          else
            nxt_msg = SPC_MSG_SEQ_COUNT;
          nxt_rs        = RS_SEND;
          nxt_out_valid = 1'b1;
          nxt_out_byte  = msg_char(nxt_msg, '0);
          nxt_idx       = SPC_IDX_W'(1);
        end
      RS_SEND:
        if (ce && out_ready)
        begin
          if (idx_ff == msg_len(msg_ff))
          begin
            nxt_rs        = RS_IDLE;
            nxt_out_valid = 1'b0;
          end
          else
          begin
            nxt_out_byte = msg_char(msg_ff, idx_ff);
            nxt_idx      = idx_ff + 1'b1;
          end
        end
    endcase
    // One command at a time; queries are held off while text streams
    nxt_ready = (nxt_rs == RS_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_ff         <= SPC_CNT_RST;                              // [RL4]
      passes_ff        <= SPC_CNT_RST;
      scan_chan_ff     <= '0;
      sq_ff            <= SQ_IDLE;
      rs_ff            <= RS_IDLE;
      msg_ff           <= SPC_MSG_VERSION;
      idx_ff           <= '0;
      relays_open_ff   <= 1'b0;
      scan_step_ff     <= 1'b0;
      trig_busy_ff     <= 1'b0;
      power_on_flag_ff <= 1'b1;
      out_valid_ff     <= 1'b0;
      out_byte_ff      <= 8'h00;
      cmd_ready_ff     <= 1'b1;
    end
    else if (ce)
    begin
      count_ff         <= nxt_count;
      passes_ff        <= nxt_passes;
      scan_chan_ff     <= nxt_chan;
      sq_ff            <= nxt_sq;
      rs_ff            <= nxt_rs;
      msg_ff           <= nxt_msg;
      idx_ff           <= nxt_idx;
      relays_open_ff   <= nxt_relays_open;
      scan_step_ff     <= nxt_step;
      trig_busy_ff     <= (nxt_sq == SQ_ARMED);
      power_on_flag_ff <= nxt_power_on;
      out_valid_ff     <= nxt_out_valid;
      out_byte_ff      <= nxt_out_byte;
      cmd_ready_ff     <= nxt_ready;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_take(spc_op_e op);
    take && cmd_op == op;
  endsequence

  property p_preset_opens;
    s_take(SPC_OP_PRESET) |=> relays_open_ff && !out_valid_ff;
  endproperty
  a_preset_opens: assert property (p_preset_opens) else $error("relays not opened"); // [RL1]

  property p_preset_keeps_flag;
    s_take(SPC_OP_PRESET) |=> $stable(power_on_flag_ff);
  endproperty
  a_preset_keeps_flag: assert property (p_preset_keeps_flag) else $error("flag changed"); // [RL2]

  property p_version_first;
    s_take(SPC_OP_VERSION_Q) |=> out_valid_ff && out_byte_ff == VERSION_TEXT[8*SPC_VER_LEN-1 -: 8];
  endproperty
  a_version_first: assert property (p_version_first) else $error("version not started"); // [RL3]

  property p_count_range;
    count_ff != '0;
  endproperty
  a_count_range: assert property (p_count_range) else $error("pass count out of range"); // [RL4]

  property p_bad_count_logged;
    s_take(SPC_OP_SET_COUNT) ##0 !cnt_ok |-> eq.push ##1 $stable(count_ff);
  endproperty
  a_bad_count_logged: assert property (p_bad_count_logged) else $error("no log entry"); // [RL9]

  property p_bad_count_kept;
    s_take(SPC_OP_SET_COUNT) ##0 !cnt_ok |=> count_ff == $past(count_ff);
  endproperty
  a_bad_count_kept: assert property (p_bad_count_kept) else $error("count overwritten"); // [RL10]

  property p_last_pass_idle;
    ce && step && last_chan && passes_ff == SPC_CNT_RST |=> !trig_busy_ff ##1 !scan_step_ff;
  endproperty
  a_last_pass_idle: assert property (p_last_pass_idle) else $error("no idle at end"); // [RL6]

  property p_pass_advance;
    ce && step && last_chan && passes_ff != SPC_CNT_RST && !stop
      |=> trig_busy_ff && scan_chan_ff == '0;
  endproperty
  a_pass_advance: assert property (p_pass_advance) else $error("pass not repeated"); // [RL5]

  property p_imm_steps;
    ce && sq_ff == SQ_ARMED && trig_src_imm && !stop |=> scan_step_ff;
  endproperty
  a_imm_steps: assert property (p_imm_steps) else $error("immediate source stalled"); // [RL7]

  property p_empty_no_error;
    s_take(SPC_OP_ERROR_Q) ##0 eq.empty |=> out_valid_ff &&
      out_byte_ff == SPC_NOERR_TXT[8*SPC_NOERR_LEN-1 -: 8];
  endproperty
  a_empty_no_error: assert property (p_empty_no_error) else $error("no-error missing"); // [RL8]
endmodule

/* File: spc_host.sv */
`timescale 1ns/1ps
module spc_host
  import spc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        cmd_ready_ff,
  input  wire logic        out_valid_ff,
  input  wire logic [7:0]  out_byte_ff,
  output      logic        cmd_valid,
  output      spc_op_e     cmd_op,
  output      logic [31:0] cmd_value,
  output      logic        out_ready
);
  logic [7:0] rx_q[$];

  initial
  begin
    cmd_valid = 1'b0;
    cmd_op    = SPC_OP_PRESET;
    cmd_value = 32'h0000_0000;
    out_ready = 1'b0;
  end

  // Reader stalls at random to prove bytes stand until taken
  always @(posedge clk)
  begin
    if (out_valid_ff && out_ready)
    begin
      rx_q.push_back(out_byte_ff);
    end
    out_ready <= #1 ~stall;
  end

  // Called just after an edge; request held until an edge with ready high
  task automatic send(input spc_op_e op, input logic [31:0] val);
    // An edge passes first, so back-to-back calls never retoggle cmd_valid
    @(posedge clk);
    #1;
    while (cmd_ready_ff !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_value = val;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import spc_pkg::*;
  ;
  // Version text; value arbitrary
  localparam logic [55:0] VER = "\"7.3.5\"";

  logic              clk          = 1'b0;
  logic              reset_n      = 1'b0;
  logic              ce           = 1'b1;
  logic              stall        = 1'b0;
  logic              trig_event   = 1'b0;
  logic              trig_src_imm = 1'b1;
  logic [11:0]       scan_len     = 12'h000;
  logic [31:0]       seed         = 32'h0000_6584;
  logic [31:0]       r_bits;
  logic              cmd_valid;
  spc_op_e           cmd_op;
  logic [31:0]       cmd_value;
  logic              cmd_ready_ff;
  logic              relays_open_ff;
  logic              scan_step_ff;
  logic [11:0]       scan_chan_ff;
  logic              trig_busy_ff;
  logic              power_on_flag_ff;
  logic              out_valid_ff;
  logic [7:0]        out_byte_ff;
  logic              out_ready;
  int                n_errors     = 0;
  int                compares     = 0;
  int                i;
  int                n;
  int                len;
  // Reference model: stored pass count and pending error entries
  int                cnt_m        = 1;
  int                errq_m[$];

  always #5 clk = ~clk;

  spc_ctrl #(.VERSION_TEXT(VER)) DUT (
    .clk(clk), .reset_n(reset_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_value(cmd_value), .cmd_ready_ff(cmd_ready_ff),
    .scan_len(scan_len), .trig_src_imm(trig_src_imm), .trig_event(trig_event),
    .relays_open_ff(relays_open_ff), .scan_step_ff(scan_step_ff),
    .scan_chan_ff(scan_chan_ff), .trig_busy_ff(trig_busy_ff),
    .power_on_flag_ff(power_on_flag_ff), .out_valid_ff(out_valid_ff),
    .out_byte_ff(out_byte_ff), .out_ready(out_ready)
  );

  spc_host host (
    .clk(clk), .stall(stall), .cmd_ready_ff(cmd_ready_ff),
    .out_valid_ff(out_valid_ff), .out_byte_ff(out_byte_ff),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_value(cmd_value),
    .out_ready(out_ready)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  always @(posedge clk)
  begin
    r_bits = rnd();
    stall      <= #1 r_bits[0] & r_bits[1];
    trig_event <= #1 r_bits[2];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic preset_chk(input logic flag);
    int hits;
    hits = 0;
    host.rx_q.delete();
    host.send(SPC_OP_PRESET, 32'h0000_0000);
    repeat (4)
    begin
      if (relays_open_ff === 1'b1)
        hits++;
      @(posedge clk);
      #1;
    end
    check(hits, 32'h0000_0001);
    check(host.rx_q.size(), 32'h0000_0000);
    check(power_on_flag_ff, flag);
  endtask

  task automatic query(input spc_op_e op, input logic [391:0] txt, input int cnt);
    int k;
    host.rx_q.delete();
    host.send(op, 32'h0000_0000);
    k = 0;
    while (cmd_ready_ff !== 1'b1 && k < 500)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(host.rx_q.size(), cnt);
    for (k = 0; k < cnt; k++)
      check(host.rx_q[k], txt[8*(cnt-1-k) +: 8]);
  endtask

  task automatic run_scan(input int passes, input int ln, input logic imm);
    int steps;
    int t;
    scan_len     = ln[11:0];
    trig_src_imm = imm;
    host.send(SPC_OP_INITIATE, 32'h0000_0000);
    steps = 0;
    for (t = 0; t < 200000 && (t < 3 || trig_busy_ff === 1'b1); t++)
    begin
      @(posedge clk);
      #1;
      if (scan_step_ff === 1'b1)
      begin
        check(scan_chan_ff, (steps + 1) % ln);
        steps++;
      end
    end
    repeat (2)
    begin
      @(posedge clk);
      #1;
      if (scan_step_ff === 1'b1)
        steps++;
    end
    check(steps, passes * ln);
    check(trig_busy_ff, 1'b0);
    if (imm)
      check(t <= passes * ln + 4, 1'b1);
  endtask

  task automatic cmd(input spc_op_e op, input logic [31:0] val);
    host.send(op, val);
    if (op == SPC_OP_SET_COUNT && val >= 1 && val <= 65535)
      cnt_m = int'(val);
    else if (op == SPC_OP_SET_COUNT)
      errq_m.push_back(int'(val));
    else if (op == SPC_OP_RESET)
      cnt_m = 1;
  endtask

  task automatic err_query();
    if (errq_m.size() > 0)
    begin
      void'(errq_m.pop_front());
      query(SPC_OP_ERROR_Q, SPC_SEQ_TXT, SPC_SEQ_LEN);
    end
    else
      query(SPC_OP_ERROR_Q, SPC_NOERR_TXT, SPC_NOERR_LEN);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check(power_on_flag_ff, 1'b1);
    preset_chk(1'b1);
    host.send(SPC_OP_ESR_CLEAR, 32'h0000_0000);
    preset_chk(1'b0);
    query(SPC_OP_VERSION_Q, VER, SPC_VER_LEN);
    query(SPC_OP_VERSION_Q, VER, SPC_VER_LEN);
    err_query();
    run_scan(cnt_m, 3, 1'b1);
    cmd(SPC_OP_SET_COUNT, 32'h0000_0003);
    cmd(SPC_OP_SET_COUNT, 32'h0000_0000);
    cmd(SPC_OP_SET_COUNT, 32'h0001_0000);
    run_scan(cnt_m, 4, 1'b0);
    err_query();
    err_query();
    err_query();
    for (i = 0; i < 3; i++)
    begin
      n   = int'(rnd() % 5) + 1;
      len = int'(rnd() % 6) + 1;
      cmd(SPC_OP_SET_COUNT, n);
      run_scan(cnt_m, len, 1'b1);
    end
    // Abort in mid-scan must drop the trigger subsystem to idle at once
    cmd(SPC_OP_SET_COUNT, 32'h0000_0005);
    scan_len = 12'h004;
    host.send(SPC_OP_INITIATE, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1;
    check(trig_busy_ff, 1'b1);
    host.send(SPC_OP_ABORT, 32'h0000_0000);
    check(trig_busy_ff, 1'b0);
    @(posedge clk);
    #1;
    check(scan_step_ff, 1'b0);
    cmd(SPC_OP_SET_COUNT, 32'h0000_FFFF);
    run_scan(cnt_m, 1, 1'b1);
    cmd(SPC_OP_RESET, 32'h0000_0000);
    run_scan(cnt_m, 5, 1'b1);
    print_verdict();
  end

  // Expected run is about 70k cycles
  initial
  begin
    #1500000;
    n_errors++;
    print_verdict();
  end
endmodule
